// >>> verilog/timer8_regs.svh
// Register offsets, field positions, reset values and timing counts of the timer pair.
// Assumes an 8-bit register port and a 125 MHz system clock.
`ifndef TIMER8_REGS_SVH
`define TIMER8_REGS_SVH

// Register offsets on the 8-bit register port
`define OFS_PAIR_CONTROL 8'h20
`define OFS_MODE_CH0 8'h22
`define OFS_MODE_CH1 8'h23
`define OFS_COMPARE_CH0 8'h24
`define OFS_COMPARE_CH1 8'h25
`define OFS_PWM_VALUE_CH0 8'h28
`define OFS_PWM_VALUE_CH1 8'h29
`define OFS_COUNT_CH0 8'h2C
`define OFS_COUNT_CH1 8'h2D

// Reset values
`define RST_PAIR_CONTROL 4'h0
`define RST_MODE 8'h00
`define RST_COMPARE 8'hFF
`define RST_PWM_VALUE 8'hFF

// Mode select field encodings
`define MODE_SEL_EVENT 2'h0
`define MODE_SEL_PWM 2'h2

// Field positions inside the pwm value register
`define PWM_DUTY_MSB 7
`define PWM_DUTY_LSB 1
`define PWM_EXTRA_BIT 0

// PWM cycle length in source clock counts and its last count
`define PWM_PERIOD 8'h80
`define PWM_LAST 8'h7F

// Width of the free-running prescaler
`define PRESCALE_BITS 11

`endif

// >>> verilog/timer8_pkg.sv
// Types shared by the timer pair: control and mode register layouts.
// Assumes the offsets and constants in timer8_regs.svh.
package timer8_pkg;

    // Pair control register
    typedef struct packed {
        logic and_combine;  // AND both channel levels onto pin 0
        logic cascade;      // Cascade select; when set, neither channel counts
        logic [1:0] run;    // Channel run bits
    } pair_control_t;

    // Per-channel mode register
    typedef struct packed {
        logic initial_level;     // Pin level before start and when stopped
        logic [2:0] clock_sel;   // Source clock select
        logic double_buffer;     // Double buffer enable
        logic external_input;    // External input select
        logic [1:0] mode_sel;    // Mode select field
    } mode_t;

endpackage

// >>> verilog/event_edge.sv
// Synchroniser and falling-edge detector for one external event pin.
// Assumes the pin is asynchronous to clock_i and held two cycles per level.
`timescale 1ns/1ps
module event_edge (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic pin_i,
    output logic fall_o
);
    logic meta_q;  // First stage, read only by the second
    logic sync_q;  // Second stage, safe to use
    logic prev_q;  // Previous synchronised sample

    // Two-stage synchroniser, then one delay for the edge
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // One pulse per high-to-low transition of the synchronised samples
    assign fall_o = prev_q & ~sync_q;
endmodule

// >>> verilog/clock_prescaler.sv
// Free-running prescaler giving one-cycle enables for the eight source clock rates.
// Assumes a single system clock; tick_o[k] matches clock select value k.
`timescale 1ns/1ps
`include "timer8_regs.svh"
module clock_prescaler #(
    parameter int DIV_W = `PRESCALE_BITS
) (
    input wire logic clock_i,
    input wire logic reset_i,
    output logic [7:0] tick_o
);
    logic [DIV_W-1:0] div_q;  // Free-running divider

    // Divide exponent for each select: 2^11, 2^10, 2^8, 2^6, 2^4, 2^2, 2, 1
    function automatic int shift_of(input int sel);
        case (sel)
            0: shift_of = 11;
            1: shift_of = 10;
            2: shift_of = 8;
            3: shift_of = 6;
            4: shift_of = 4;
            5: shift_of = 2;
            6: shift_of = 1;
            default: shift_of = 0;
        endcase
    endfunction

    // The widest divide needs eleven bits; refuse a narrower divider at elaboration
    if (DIV_W < 11) begin : g_width_check
        $error("clock_prescaler: DIV_W must be at least 11");
    end

    // Counter advances every cycle
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // A rate ticks when its low bits are all ones
    for (genvar k = 0; k < 8; k++) begin : g_tick
        localparam logic [DIV_W-1:0] MASK = DIV_W'((1 << shift_of(k)) - 1);
        assign tick_o[k] = (div_q & MASK) == MASK;
    end
endmodule

// >>> verilog/timer8_pair.sv
// Two 8-bit timer/counter channels with event counter and 7-bit PWM modes.
// Assumes a plain register port on clock_i with read data one cycle later,
// and asynchronous event pins.
`timescale 1ns/1ps
`include "timer8_regs.svh"
module timer8_pair (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [1:0] event_i,
    output logic [1:0] pwm_o,
    output logic [1:0] match_irq_o
);
    // Pair control register, shared by both channels
    timer8_pkg::pair_control_t ctrl_q;
    // Source clock enables from the prescaler
    logic [7:0] tick_v;
    // Per-channel views for the read mux and the pin stage
    logic [1:0][7:0] mode_v;
    logic [1:0][7:0] cmp_buf_v;
    logic [1:0][7:0] pwm_buf_v;
    logic [1:0][7:0] cnt_v;
    logic [1:0] level_v;
    logic [1:0] irq_v;
    // Registered read data
    logic [7:0] rdata_q;
    // Registered pin levels and interrupt pulses
    logic [1:0] pwm_q;
    logic [1:0] irq_q;

    // Channel counts in event counter mode
    function automatic logic is_event_mode(input timer8_pkg::mode_t m, input logic cascade);
        is_event_mode = (m.mode_sel == `MODE_SEL_EVENT) && !cascade && m.external_input;
    endfunction

    // Channel runs as a PWM generator
    function automatic logic is_pwm_mode(input timer8_pkg::mode_t m, input logic cascade);
        is_pwm_mode = (m.mode_sel == `MODE_SEL_PWM) && !cascade && !m.external_input;
    endfunction

    // One prescaler serves both channels; each picks its own rate
    clock_prescaler #(
        .DIV_W(`PRESCALE_BITS)
    ) u_prescaler (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .tick_o(tick_v)
    );

    // Pair control write; run, cascade and AND combine are always writable
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ctrl_q <= timer8_pkg::pair_control_t'(`RST_PAIR_CONTROL);
        end else if (wr_i && addr_i == `OFS_PAIR_CONTROL) begin
            ctrl_q <= timer8_pkg::pair_control_t'(wdata_i[3:0]);
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_ch
        timer8_pkg::mode_t mode_q;  // Mode register, frozen while running
        logic [7:0] cmp_buf_q;      // Last written compare value
        logic [7:0] cmp_act_q;      // Compare value in use
        logic [7:0] pwm_buf_q;      // Last written pwm value
        logic [7:0] pwm_act_q;      // Pwm value in use
        logic [7:0] cnt_q;          // Up counter
        logic [6:0] duty_q;         // Duty sampled at overflow
        logic extra_q;              // Extra count enable sampled at overflow
        logic pair_q;               // High during the second cycle of a pair
        logic level_q;              // Channel output level
        logic run;                  // Channel run bit
        logic ev_mode;              // Event counter mode decoded
        logic pw_mode;              // PWM mode decoded
        logic fall;                 // Falling edge on the event pin
        logic step;                 // Counter advances this cycle
        logic [7:0] cnt_next;       // Counter plus one
        logic ev_match;             // Event count reaches compare
        logic wrap;                 // PWM count passes its last value
        logic [6:0] duty;           // Duty width in use
        logic extra;                // Extra count enable in use
        logic [7:0] mpoint;         // Count at which the output toggles
        logic [7:0] pwm_src;        // Value sampled for the next cycle
        logic wr_mode;              // Write strobes decoded per register
        logic wr_cmp;
        logic wr_pwm;

        assign run = ctrl_q.run[i];
        assign ev_mode = is_event_mode(mode_q, ctrl_q.cascade);
        assign pw_mode = is_pwm_mode(mode_q, ctrl_q.cascade);
        assign wr_mode = wr_i && (addr_i == (i == 0 ? `OFS_MODE_CH0 : `OFS_MODE_CH1));
        assign wr_cmp = wr_i && (addr_i == (i == 0 ? `OFS_COMPARE_CH0 : `OFS_COMPARE_CH1));
        assign wr_pwm = wr_i && (addr_i == (i == 0 ? `OFS_PWM_VALUE_CH0 : `OFS_PWM_VALUE_CH1));

        // Edge detector for this channel's event pin
        event_edge u_edge (
            .clock_i(clock_i),
            .reset_i(reset_i),
            .pin_i(event_i[i]),
            .fall_o(fall)
        );

        // Counting source: pin edges or the selected prescaler rate.
        // The source must respect the minimum level widths or edges are lost.
        assign step = run && (ev_mode ? fall : (pw_mode && tick_v[mode_q.clock_sel]));
        assign cnt_next = cnt_q + 8'h01;
        assign ev_match = cnt_next == cmp_act_q;
        assign wrap = cnt_q == `PWM_LAST;

        // Buffered settings hold for a whole cycle; unbuffered ones act at once
        assign duty = mode_q.double_buffer ? duty_q : pwm_act_q[`PWM_DUTY_MSB:`PWM_DUTY_LSB];
        assign extra = mode_q.double_buffer ? extra_q : pwm_act_q[`PWM_EXTRA_BIT];
        // Second cycle of each pair toggles one count later when extra is set
        assign mpoint = {1'b0, duty} + {7'h00, extra & pair_q};
        // At the interrupt overflow the buffered value becomes the one to sample
        assign pwm_src = (pair_q && mode_q.double_buffer) ? pwm_buf_q : pwm_act_q;

        // Mode register; ignored while the channel runs
        always_ff @(posedge clock_i) begin
            if (reset_i) begin
                mode_q <= timer8_pkg::mode_t'(`RST_MODE);
            end else if (wr_mode && !run) begin
                mode_q <= timer8_pkg::mode_t'(wdata_i);
            end
        end

        // Compare value with optional double buffer
        always_ff @(posedge clock_i) begin
            if (reset_i) begin
                cmp_buf_q <= `RST_COMPARE;
                cmp_act_q <= `RST_COMPARE;
            end else begin
                if (wr_cmp) begin
                    cmp_buf_q <= wdata_i;
                end
                // Stopped or unbuffered: both copies take the write
                if (wr_cmp && (!run || !mode_q.double_buffer)) begin
                    cmp_act_q <= wdata_i;
                end else if (step && ev_mode && ev_match && mode_q.double_buffer) begin
                    // Buffered value takes over at the match
                    cmp_act_q <= cmp_buf_q;
                end
            end
        end

        // PWM value with optional double buffer; reads see the buffer
        always_ff @(posedge clock_i) begin
            if (reset_i) begin
                pwm_buf_q <= `RST_PWM_VALUE;
                pwm_act_q <= `RST_PWM_VALUE;
            end else begin
                if (wr_pwm) begin
                    pwm_buf_q <= wdata_i;
                end
                if (wr_pwm && (!run || !mode_q.double_buffer)) begin
                    pwm_act_q <= wdata_i;
                end else if (step && pw_mode && wrap && pair_q && mode_q.double_buffer) begin
                    // Loaded only at the overflow that raises the interrupt
                    pwm_act_q <= pwm_buf_q;
                end
            end
        end

        // Duty and extra sampled while stopped and at every overflow
        always_ff @(posedge clock_i) begin
            if (reset_i) begin
                // Reset duty is the upper seven bits of the reset pwm value
                duty_q <= 7'(`RST_PWM_VALUE >> 1);
                extra_q <= 1'b1;
            end else if (!run) begin
                duty_q <= pwm_act_q[`PWM_DUTY_MSB:`PWM_DUTY_LSB];
                extra_q <= pwm_act_q[`PWM_EXTRA_BIT];
            end else if (step && pw_mode && wrap) begin
                duty_q <= pwm_src[`PWM_DUTY_MSB:`PWM_DUTY_LSB];
                extra_q <= pwm_src[`PWM_EXTRA_BIT];
            end
        end

        // Up counter
        always_ff @(posedge clock_i) begin
            if (reset_i) begin
                cnt_q <= 8'h00;
            end else if (!run) begin
                // Stopping holds the counter at zero
                cnt_q <= 8'h00;
            end else if (step) begin
                if (ev_mode) begin
                    // Compare match clears; otherwise count one edge
                    cnt_q <= ev_match ? 8'h00 : cnt_next;
                end else begin
                    // 128 counts per PWM cycle
                    cnt_q <= wrap ? 8'h00 : cnt_next;
                end
            end
        end

        // Pair phase: flips at each overflow so every second one is marked
        always_ff @(posedge clock_i) begin
            if (reset_i || !run) begin
                pair_q <= 1'b0;
            end else if (step && pw_mode && wrap) begin
                pair_q <= ~pair_q;
            end
        end

        // Output level
        always_ff @(posedge clock_i) begin
            if (reset_i) begin
                level_q <= 1'b0;
            end else if (!run) begin
                // Stopped: initial level on the pin
                level_q <= mode_q.initial_level;
            end else if (step && pw_mode) begin
                if (wrap) begin
                    // Overflow restores the initial level; zero duty toggles at once
                    level_q <= (pwm_src[`PWM_DUTY_MSB:`PWM_DUTY_LSB] == 7'h00) ?
                        ~mode_q.initial_level : mode_q.initial_level;
                end else if (cnt_next == mpoint) begin
                    // Duty match moves away from the initial level
                    level_q <= ~mode_q.initial_level;
                end
            end
        end

        assign mode_v[i] = mode_q;
        assign cmp_buf_v[i] = cmp_buf_q;
        assign pwm_buf_v[i] = pwm_buf_q;
        assign cnt_v[i] = cnt_q;
        assign level_v[i] = level_q;
        // Match interrupt: every compare match, or every second PWM overflow
        assign irq_v[i] = step && (ev_mode ? ev_match : (pw_mode && wrap && pair_q));
    end

    // Pin stage; AND combine lets channel 0's pin carry both levels
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pwm_q <= 2'h0;
        end else begin
            pwm_q[0] <= ctrl_q.and_combine ? (level_v[0] & level_v[1]) : level_v[0];
            pwm_q[1] <= level_v[1];
        end
    end

    // Interrupt pulses, one cycle each
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            irq_q <= 2'h0;
        end else begin
            irq_q <= irq_v;
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock_i) begin
        if (reset_i || !rd_i) begin
            rdata_q <= 8'h00;
        end else begin
            case (addr_i)
                `OFS_PAIR_CONTROL: rdata_q <= {4'h0, ctrl_q};
                `OFS_MODE_CH0: rdata_q <= mode_v[0];
                `OFS_MODE_CH1: rdata_q <= mode_v[1];
                `OFS_COMPARE_CH0: rdata_q <= cmp_buf_v[0];
                `OFS_COMPARE_CH1: rdata_q <= cmp_buf_v[1];
                `OFS_PWM_VALUE_CH0: rdata_q <= pwm_buf_v[0];
                `OFS_PWM_VALUE_CH1: rdata_q <= pwm_buf_v[1];
                `OFS_COUNT_CH0: rdata_q <= cnt_v[0];
                `OFS_COUNT_CH1: rdata_q <= cnt_v[1];
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign rdata_o = rdata_q;
    assign pwm_o = pwm_q;
    assign match_irq_o = irq_q;
endmodule

// >>> verif/timer8_pair_properties.sv
// Port-level checker of the timer pair, channel 0 mostly, with its bind.
// Assumes the offsets of timer8_regs.svh and the mode layout of timer8_pkg.
`timescale 1ns/1ps
`include "timer8_regs.svh"
module timer8_pair_properties (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] event_i,
    input wire logic [1:0] pwm_o,
    input wire logic [1:0] match_irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    logic [1:0] run_q; // Run bits as last written
    logic and_q; // AND combine as last written
    timer8_pkg::mode_t mode0_q; // Mode the device must hold for ch0
    timer8_pkg::mode_t mode1_q; // Same for ch1
    logic [3:0] calm_q; // Cycles since a control or mode write
    logic [15:0] gap_q; // Cycles since the last ch0 interrupt
    logic gap_ok_q; // Gap lies inside one steady full-rate PWM run
    logic [7:0] age_q; // Cycles since the ch0 pin last fell
    logic ctl_wr;
    logic pwm7;
    logic ev_run;
    assign ctl_wr = wr_i && addr_i == `OFS_PAIR_CONTROL;
    assign pwm7 = run_q[0] && mode0_q.mode_sel == `MODE_SEL_PWM && mode0_q.clock_sel == 3'h7;
    assign ev_run = run_q[0] && mode0_q.mode_sel == `MODE_SEL_EVENT && mode0_q.external_input;
    // Shadow registers; a mode write is dropped while its channel runs
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            run_q <= 2'h0;
            and_q <= 1'b0;
            mode0_q <= `RST_MODE;
            mode1_q <= `RST_MODE;
        end else begin
            if (ctl_wr) begin
                run_q <= wdata_i[1:0];
                and_q <= wdata_i[3];
            end
            if (wr_i && addr_i == `OFS_MODE_CH0 && !run_q[0]) begin
                mode0_q <= wdata_i;
            end
            if (wr_i && addr_i == `OFS_MODE_CH1 && !run_q[1]) begin
                mode1_q <= wdata_i;
            end
        end
    end
    // Settling and spacing counters
    always_ff @(posedge clock_i) begin
        if (reset_i || ctl_wr || (wr_i && addr_i[7:1] == 7'h11)) begin
            calm_q <= 4'h0;
        end else if (calm_q != 4'hF) begin
            calm_q <= calm_q + 4'h1;
        end
        gap_q <= match_irq_o[0] ? 16'h0000 : gap_q + 16'h0001;
        // Only a gap between two interrupts of one run is meaningful
        if (reset_i || ctl_wr) begin
            gap_ok_q <= 1'b0;
        end else if (match_irq_o[0] && pwm7) begin
            gap_ok_q <= 1'b1;
        end
        age_q <= (reset_i || $fell(event_i[0])) ? 8'h00 : (age_q == 8'hFF ? age_q : age_q + 8'h01);
    end
    a_reset_quiet:
        assert property ($fell(reset_i) |-> pwm_o == 2'h0 && match_irq_o == 2'h0) else $error("outputs busy after reset");
    a_irq_single:
        assert property (match_irq_o[0] |=> !match_irq_o[0]) else $error("interrupt pulse too long");
    a_irq_period:
        assert property (match_irq_o[0] && gap_ok_q |-> gap_q == 16'd255) else $error("PWM interrupt spacing wrong");
    a_event_cause:
        assert property (match_irq_o[0] && ev_run |-> age_q inside {[8'd1:8'd8]}) else $error("match without pin edge");
    a_mode_frozen:
        assert property (rd_i && addr_i == `OFS_MODE_CH0 |=> rdata_o == mode0_q) else $error("mode readback wrong");
    a_pwm_readback:
        assert property (wr_i && addr_i == `OFS_PWM_VALUE_CH0 ##1 !wr_i ##1 rd_i && addr_i == `OFS_PWM_VALUE_CH0
            |=> rdata_o == $past(wdata_i, 3)) else $error("pwm value readback wrong");
    a_stopped_level:
        assert property (calm_q >= 4'h3 && run_q == 2'h0 && !and_q
            |-> pwm_o == {mode1_q.initial_level, mode0_q.initial_level}) else $error("stopped pin level wrong");
    a_and_combine:
        assert property (calm_q >= 4'h3 && run_q == 2'h0 && and_q
            |-> pwm_o[0] == (mode0_q.initial_level & mode1_q.initial_level)) else $error("AND combine wrong");
endmodule
bind timer8_pair timer8_pair_properties chk_u (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_i(event_i), .pwm_o(pwm_o),
    .match_irq_o(match_irq_o));

// >>> verif/pulse_source_load.sv
// Far side: event source on both pins and a load timing the high phases of one PWM pin.
// Assumes the bench clock; pins idle high between bursts, as a real source may hold them.
`timescale 1ns/1ps
module pulse_source_load (
    input wire logic clock_i,
    input wire logic pwm_i,
    output logic [1:0] event_o,
    output int hi_last_o,
    output int hi_prev_o
);
    int run_len = 0; // High cycles of the phase in progress
    initial begin
        event_o = 2'h3;
        hi_last_o = 0;
        hi_prev_o = 0;
    end
    // Falling edges on one pin; each level stands hold cycles, two or more
    task automatic fall_edges(input int ch, input int n, input int hold);
        repeat (n) begin
            @(posedge clock_i);
            event_o[ch] <= 1'b0;
            repeat (hold) @(posedge clock_i);
            event_o[ch] <= 1'b1;
            repeat (hold - 1) @(posedge clock_i);
        end
    endtask
    // Keep the two latest high phase lengths
    always @(posedge clock_i) begin
        if (pwm_i === 1'b1) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            hi_prev_o <= hi_last_o;
            hi_last_o <= run_len;
            run_len <= 0;
        end
    end
endmodule

// >>> verif/test_timer8_pair.sv
// Self-checking bench of the timer pair: registers, event counting and PWM on channel 0.
// Assumes the design under verilog/ and the far-side model pulse_source_load.
`timescale 1ns/1ps
`include "timer8_regs.svh"
`define CHECK_EQ(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module test_timer8_pair;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic [7:0] rd_v;
    logic [1:0] event_i;
    logic [1:0] pwm_o;
    logic [1:0] match_irq_o;
    logic [7:0] mdl [0:255]; // Readback model of the register map
    logic [7:0] regs [4] = '{8'h22, 8'h23, 8'h24, 8'h29}; // Places for random readback
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int irq_seen = 0; // Ch0 interrupt pulses seen
    int irq1_seen = 0; // Ch1 interrupt pulses seen; ch1 never runs here
    int seed = 32'h1e3577bc;
    int ev_cnt = 0; // Model counter, compare and buffer of ch0
    int cmp_act = 255;
    int cmp_buf = 255;
    int irq_exp = 0;
    int n, d, x, i0;
    always #4 clock_i = ~clock_i;
    timer8_pair dut_u (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .event_i(event_i), .pwm_o(pwm_o), .match_irq_o(match_irq_o));
    pulse_source_load src_u (.clock_i(clock_i), .pwm_i(pwm_o[0]), .event_o(event_i), .hi_last_o(),
        .hi_prev_o());
    task automatic end_of_test();
        $display("errors %0d, comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Cut a hang short and count interrupts
    always @(posedge clock_i) begin
        cycles++;
        if (match_irq_o[0] === 1'b1) irq_seen++;
        if (match_irq_o[1] !== 1'b0) irq1_seen++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    // One write cycle; the model drops mode writes of a running channel
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clock_i);
        wr_i <= 1'b0;
        if (a == `OFS_COMPARE_CH0) begin
            cmp_buf = v;
            if (!(mdl[`OFS_PAIR_CONTROL][0] && mdl[`OFS_MODE_CH0][3])) cmp_act = v;
        end
        if (a == `OFS_PAIR_CONTROL && !v[0]) ev_cnt = 0;
        if (!(a[7:1] == 7'h11 && mdl[`OFS_PAIR_CONTROL][a[0]])) mdl[a] = v;
    endtask
    // One read cycle; data are taken in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        rd_v = rdata_o;
        `CHECK_EQ(rd_v, e)
    endtask
    // Falling edges on the ch0 pin, mirrored in the model
    task automatic ev(input int k);
        src_u.fall_edges(0, k, 2 + $unsigned($random(seed)) % 2);
        for (int i = 0; i < k; i++) begin
            ev_cnt = (ev_cnt + 1) % 256;
            if (ev_cnt == cmp_act) begin
                ev_cnt = 0;
                irq_exp++;
                cmp_act = cmp_buf;
            end
        end
        repeat (8) @(posedge clock_i);
    endtask
    initial begin
        for (int i = 0; i < 256; i++) mdl[i] = 8'h00;
        mdl[8'h24] = `RST_COMPARE;
        mdl[8'h25] = `RST_COMPARE;
        mdl[8'h28] = `RST_PWM_VALUE;
        mdl[8'h29] = `RST_PWM_VALUE;
        repeat (4) @(posedge clock_i);
        reset_i <= 1'b0;
        rd_chk(`OFS_PWM_VALUE_CH0, 8'hFF);
        rd_chk(`OFS_PWM_VALUE_CH1, 8'hFF);
        rd_chk(8'h40, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr_reg(regs[i % 4], $random(seed));
            rd_chk(regs[i % 4], mdl[regs[i % 4]]);
        end
        // Event counting with a compare value changed in mid-run through the buffer
        n = 2 + $unsigned($random(seed)) % 5;
        wr_reg(`OFS_MODE_CH0, 8'h0C);
        wr_reg(`OFS_COMPARE_CH0, n[7:0]);
        wr_reg(`OFS_PAIR_CONTROL, 8'h01);
        wr_reg(`OFS_MODE_CH0, 8'h72);
        rd_chk(`OFS_MODE_CH0, mdl[`OFS_MODE_CH0]);
        wr_reg(`OFS_COMPARE_CH0, 8'h02);
        ev(n + 3);
        `CHECK_EQ(irq_seen, irq_exp)
        rd_chk(`OFS_COUNT_CH0, ev_cnt[7:0]);
        wr_reg(`OFS_PAIR_CONTROL, 8'h00);
        rd_chk(`OFS_COUNT_CH0, 8'h00);
        // PWM at full rate, both initial levels, buffer on for the second
        for (int k = 0; k < 2; k++) begin
            d = 1 + $unsigned($random(seed)) % 100;
            x = $random(seed) & 1;
            wr_reg(`OFS_MODE_CH0, {k[0], 3'h7, k[0], 3'h2});
            wr_reg(`OFS_PWM_VALUE_CH0, {d[6:0], x[0]});
            wr_reg(`OFS_PAIR_CONTROL, 8'h01);
            repeat (600) @(posedge clock_i);
            i0 = irq_seen;
            repeat (512) @(posedge clock_i);
            `CHECK_EQ(irq_seen - i0, 2)
            `CHECK_EQ(src_u.hi_last_o + src_u.hi_prev_o, k ? 2 * d + x : 256 - 2 * d - x)
            wr_reg(`OFS_PWM_VALUE_CH0, 8'h11);
            rd_chk(`OFS_PWM_VALUE_CH0, 8'h11);
            wr_reg(`OFS_PAIR_CONTROL, 8'h00);
            repeat (3) @(posedge clock_i);
            `CHECK_EQ(pwm_o[0], k[0])
            rd_chk(`OFS_COUNT_CH0, 8'h00);
        end
        // Pin 0 carries the AND of both stopped levels
        wr_reg(`OFS_MODE_CH0, 8'h80);
        wr_reg(`OFS_MODE_CH1, 8'h80);
        wr_reg(`OFS_PAIR_CONTROL, 8'h08);
        repeat (3) @(posedge clock_i);
        `CHECK_EQ(pwm_o, 2'h3)
        wr_reg(`OFS_MODE_CH1, 8'h00);
        repeat (3) @(posedge clock_i);
        `CHECK_EQ(pwm_o, 2'h0)
        `CHECK_EQ(irq1_seen, 0)
        end_of_test();
    end
endmodule
